// [rtl/rcs_top.sv]
// reset control sequencer: reset sources, cause flags, boot fetch and apb registers
//
// Functional notes
// - Five reset requests are accepted: reset pin, power-on, brown-out, software, watchdog.
// - Every reset sets the cause flag of the source that triggered it.
// - Cause flags are sticky and survive later reset sequences of other kinds.
// - A power-on reset clears all other cause flags and leaves only the power-on flag.
// - The reset pin resets core and peripherals but leaves the test-access controller alone.
// - The pin is driven low then released by the outside, then the internal reset releases.
// - Pin release passes a synchroniser, delaying the release sequence by a few clocks.
// - At power-up the internal reset holds until both power-on and pin are inactive.
// - After release the core fetches stack pointer, program counter, then first instruction.
// - The power-on request is honoured only at initial power-up, never again after.
// - A power-on reset also resets the test-access controller.
// - With brown-out reset enabled, brown-out acts like the pin and holds until recovery.
// - Brown-out resets only when its enable is set; the enable is clear out of reset.
// - Setting then clearing a peripheral's soft reset bit resets that whole peripheral.
// - A qualified second watchdog timeout asserts the system reset, then restarts the core.
`timescale 1ns/1ps
module rcs_top
    import rcs_pkg::*;
#(
    parameter int NPERIPH = 8,
    parameter int RST_CYC = RST_MIN_CYC
) (
    input wire logic pclk, // system clock, 10 mhz
    input wire logic presetn, // async power-up reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, high for write
    input wire logic [APB_AW-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic rst_pin_n, // external reset pin, active low, async
    input wire logic por_n, // power-on detector, low while active, async
    input wire logic bor_detect, // brown-out detector, high while active, async
    input wire logic system_reset_request, // core software reset pulse
    input wire logic wdt_second_timeout, // watchdog second timeout pulse
    input wire logic boot_ack, // boot fetch data valid
    input wire logic [31:0] boot_rdata, // boot fetch data
    output logic sys_rst_n, // core and peripheral reset, active low
    output logic tap_rst_n, // test-access controller reset, active low
    output logic [NPERIPH-1:0] periph_rst_n, // per-peripheral reset, active low
    output logic boot_req, // boot fetch request level
    output logic [31:0] boot_addr, // boot fetch address
    output logic [31:0] init_sp, // fetched initial stack pointer
    output logic [31:0] init_pc, // fetched initial program counter
    output logic [31:0] first_insn, // fetched first instruction
    output logic core_run, // core may execute
    output logic irq // level interrupt
);
    localparam int CW = $clog2(RST_CYC + 1);
    localparam logic [CW-1:0] CNT_LOAD = CW'(RST_CYC - 1);
    localparam logic [CAUSE_W-1:0] POR_ONLY = CAUSE_W'(1) << CAUSE_POR;

    // elaboration refuses parameter values that the logic cannot serve
    if (NPERIPH < 1 || NPERIPH > 32) begin : g_bad_nperiph
        $error("rcs_top: NPERIPH must be 1 to 32");
    end
    if (RST_CYC < 1) begin : g_bad_rst_cyc
        $error("rcs_top: RST_CYC must be at least 1");
    end

    logic [2:0] sync_lv;
    logic pin_ok, por_ok, bor_hi;
    logic pin_ok_q_ff, bor_hi_q_ff, por_done_ff;
    logic por_act, bor_act, level_act, sw_req, wdt_req, pulse_req, any_req, pin_fall;
    rcs_state_t state_ff, nxt_state;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic [CAUSE_W-1:0] cause_ff, nxt_cause, cause_set, cause_clr;
    logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl;
    logic [NPERIPH-1:0] srst_ff, nxt_srst, srst_fall;
    logic [IRQ_W-1:0] istat_ff, nxt_istat, iset, iclr, imask_ff, nxt_imask;
    logic sys_rst_n_ff, nxt_sys_rst_n, tap_rst_n_ff, irq_ff;
    logic [NPERIPH-1:0] periph_rst_n_ff, nxt_periph_rst_n;
    logic boot_req_ff, nxt_boot_req, core_run_ff, nxt_core_run;
    logic [31:0] boot_addr_ff, nxt_boot_addr, init_sp_ff, init_pc_ff, first_insn_ff;
    logic [31:0] nxt_init_pc, prdata_ff, nxt_prdata, rd_mux;
    logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
    logic acc, wr_en, addr_ok, take;

    // asynchronous detector levels pass four flops before the sequencer sees them
    rcs_sync #(.WIDTH(3), .RESET_VAL(3'h0)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({bor_detect, por_n, rst_pin_n}),
        .sync_out(sync_lv)
    );
    assign pin_ok = sync_lv[0];
    assign por_ok = sync_lv[1];
    assign bor_hi = sync_lv[2];

    // request qualification
    assign por_act = ~por_ok & ~por_done_ff;
    assign bor_act = bor_hi & ctrl_ff[CTRL_BOR_EN];
    assign level_act = ~pin_ok | por_act | bor_act;
    assign sw_req = system_reset_request;
    assign wdt_req = wdt_second_timeout & ctrl_ff[CTRL_WDT_EN];
    assign pulse_req = sw_req | wdt_req;
    assign any_req = level_act | pulse_req;
    // pin held low since power-up is no pin event, so power-on stays the only cause
    assign pin_fall = pin_ok_q_ff & ~pin_ok;

    // sequencer: hold while a level source stands, stretch, then fetch the boot words
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            ST_HOLD: begin
                if (!any_req) begin
                    nxt_state = ST_STRETCH;
                    nxt_cnt = CNT_LOAD;
                end
            end
            ST_STRETCH: begin
                if (any_req) begin
                    nxt_state = ST_HOLD;
                end else if (cnt_ff == '0) begin
                    nxt_state = ST_FETCH_SP;
                end else begin
                    nxt_cnt = cnt_ff - CW'(1);
                end
            end
            ST_FETCH_SP: begin
                if (any_req) nxt_state = ST_HOLD;
                else if (boot_ack) nxt_state = ST_FETCH_PC;
            end
            ST_FETCH_PC: begin
                if (any_req) nxt_state = ST_HOLD;
                else if (boot_ack) nxt_state = ST_FETCH_INSN;
            end
            ST_FETCH_INSN: begin
                if (any_req) nxt_state = ST_HOLD;
                else if (boot_ack) nxt_state = ST_RUN;
            end
            ST_RUN: begin
                if (any_req) nxt_state = ST_HOLD;
            end
            default: begin
                nxt_state = ST_HOLD;
            end
        endcase
    end

    // reset outputs follow the next state so a request shows one edge later
    assign nxt_sys_rst_n = (nxt_state != ST_HOLD) && (nxt_state != ST_STRETCH);
    assign srst_fall = srst_ff & ~nxt_srst;
    assign nxt_periph_rst_n = {NPERIPH{nxt_sys_rst_n}} & ~srst_fall;
    assign nxt_boot_req = (nxt_state == ST_FETCH_SP) || (nxt_state == ST_FETCH_PC)
                          || (nxt_state == ST_FETCH_INSN);
    assign nxt_core_run = (nxt_state == ST_RUN);
    assign nxt_init_pc = (state_ff == ST_FETCH_PC && boot_ack) ? boot_rdata : init_pc_ff;
    assign nxt_boot_addr = (nxt_state == ST_FETCH_SP) ? VEC_SP :
                           (nxt_state == ST_FETCH_PC) ? VEC_PC : nxt_init_pc;

    // apb decode: one wait state so that read data leaves a flop
    assign acc = psel & penable;
    assign take = acc & ~pready_ff;
    assign wr_en = acc & pready_ff & pwrite;
    assign addr_ok = (paddr == ADDR_CAUSE) || (paddr == ADDR_CTRL) || (paddr == ADDR_SRST)
                     || (paddr == ADDR_IRQ_STAT) || (paddr == ADDR_IRQ_MASK)
                     || (paddr == ADDR_STATUS);
    assign rd_mux = (paddr == ADDR_CAUSE) ? {27'h0, cause_ff} :
                    (paddr == ADDR_CTRL) ? {30'h0, ctrl_ff} :
                    (paddr == ADDR_SRST) ? 32'(srst_ff) :
                    (paddr == ADDR_IRQ_STAT) ? {30'h0, istat_ff} :
                    (paddr == ADDR_IRQ_MASK) ? {30'h0, imask_ff} :
                    (paddr == ADDR_STATUS) ? {26'h0, core_run_ff, sys_rst_n_ff,
                                              state_ff, por_done_ff} : 32'h0;
    assign nxt_pready = take;
    assign nxt_prdata = take ? (pwrite ? 32'h0 : rd_mux) : prdata_ff;
    assign nxt_pslverr = take & ~addr_ok;

    // cause flags: sources in one episode all set; set wins over a write-one clear
    assign cause_set[CAUSE_EXT] = pin_fall;
    assign cause_set[CAUSE_POR] = por_act;
    assign cause_set[CAUSE_BOR] = bor_act;
    assign cause_set[CAUSE_WDT] = wdt_req;
    assign cause_set[CAUSE_SW] = sw_req;
    assign cause_clr = (wr_en && paddr == ADDR_CAUSE) ? pwdata[CAUSE_W-1:0] : '0;
    assign nxt_cause = por_act ? POR_ONLY : ((cause_ff & ~cause_clr) | cause_set);

    // software controls; brown-out reset starts disabled
    assign nxt_ctrl = (wr_en && paddr == ADDR_CTRL) ? pwdata[CTRL_W-1:0] : ctrl_ff;
    assign nxt_srst = (wr_en && paddr == ADDR_SRST) ? pwdata[NPERIPH-1:0] : srst_ff;

    // interrupt events: brown-out seen (even when not resetting) and boot finished
    assign iset[IRQ_BOR] = bor_hi & ~bor_hi_q_ff;
    assign iset[IRQ_BOOT] = nxt_core_run & ~core_run_ff;
    assign iclr = (wr_en && paddr == ADDR_IRQ_STAT) ? pwdata[IRQ_W-1:0] : '0;
    assign nxt_istat = (istat_ff & ~iclr) | iset;
    assign nxt_imask = (wr_en && paddr == ADDR_IRQ_MASK) ? pwdata[IRQ_W-1:0] : imask_ff;

    // sequencer and output flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_HOLD;
            cnt_ff <= '0;
            sys_rst_n_ff <= 1'b0;
            tap_rst_n_ff <= 1'b0;
            periph_rst_n_ff <= '0;
            boot_req_ff <= 1'b0;
            core_run_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            sys_rst_n_ff <= nxt_sys_rst_n;
            tap_rst_n_ff <= ~por_act;
            periph_rst_n_ff <= nxt_periph_rst_n;
            boot_req_ff <= nxt_boot_req;
            core_run_ff <= nxt_core_run;
        end
    end

    // boot words; no reset needed beyond a defined start value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_addr_ff <= VEC_SP;
            init_sp_ff <= 32'h0;
            init_pc_ff <= 32'h0;
            first_insn_ff <= 32'h0;
        end else begin
            boot_addr_ff <= nxt_boot_addr;
            init_sp_ff <= (state_ff == ST_FETCH_SP && boot_ack) ? boot_rdata : init_sp_ff;
            init_pc_ff <= nxt_init_pc;
            first_insn_ff <= (state_ff == ST_FETCH_INSN && boot_ack) ? boot_rdata
                                                                      : first_insn_ff;
        end
    end

    // register file lives on presetn only, so internal resets never clear it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_ff <= '0;
            ctrl_ff <= CTRL_RESET;
            srst_ff <= '0;
            istat_ff <= '0;
            imask_ff <= '0;
            irq_ff <= 1'b0;
            pin_ok_q_ff <= 1'b0;
            bor_hi_q_ff <= 1'b0;
            por_done_ff <= 1'b0;
        end else begin
            cause_ff <= nxt_cause;
            ctrl_ff <= nxt_ctrl;
            srst_ff <= nxt_srst;
            istat_ff <= nxt_istat;
            imask_ff <= nxt_imask;
            irq_ff <= |(nxt_istat & nxt_imask);
            pin_ok_q_ff <= pin_ok;
            bor_hi_q_ff <= bor_hi;
            por_done_ff <= por_done_ff | por_ok;
        end
    end

    // apb answer flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else begin
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign sys_rst_n = sys_rst_n_ff;
    assign tap_rst_n = tap_rst_n_ff;
    assign periph_rst_n = periph_rst_n_ff;
    assign boot_req = boot_req_ff;
    assign boot_addr = boot_addr_ff;
    assign init_sp = init_sp_ff;
    assign init_pc = init_pc_ff;
    assign first_insn = first_insn_ff;
    assign core_run = core_run_ff;
    assign irq = irq_ff;

    // checks on the sequencer
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence sp_done_s;
        state_ff == ST_FETCH_SP && boot_ack && !any_req;
    endsequence
    sequence pc_done_s;
        state_ff == ST_FETCH_PC && boot_ack && !any_req;
    endsequence

    por_clears_a: assert property (por_act |=> cause_ff == POR_ONLY)
        else $error("power-on did not leave only its own flag");
    level_holds_a: assert property (level_act |=> !sys_rst_n_ff && !core_run_ff)
        else $error("internal reset released while a level source stands");
    tap_kept_a: assert property ((!pin_ok && por_ok) |=> tap_rst_n_ff)
        else $error("test-access reset asserted without power-on");
    flag_sticky_a: assert property ((cause_ff[CAUSE_SW] && cause_clr[CAUSE_SW] == 1'b0
                                     && !por_act) |=> cause_ff[CAUSE_SW])
        else $error("sticky cause flag lost");
    boot_order_a: assert property (sp_done_s ##[1:4] pc_done_s |=> state_ff == ST_FETCH_INSN
                                   && boot_addr_ff == init_pc_ff)
        else $error("boot fetch order broken");
    release_path_a: assert property ($rose(sys_rst_n_ff) |-> $past(state_ff) == ST_STRETCH
                                     && $past(cnt_ff) == '0)
        else $error("internal reset released outside the stretch end");
    wdt_reset_a: assert property (wdt_req |=> !sys_rst_n_ff ##1 !sys_rst_n_ff)
        else $error("watchdog request did not hold the reset");
    sw_cause_a: assert property ((sw_req && !por_act) |=> cause_ff[CAUSE_SW])
        else $error("software reset flag not set");
    periph_pulse_a: assert property (|srst_fall |=> !(&periph_rst_n_ff))
        else $error("soft reset clear gave no peripheral reset");
    bor_gated_a: assert property ((state_ff == ST_RUN && !ctrl_ff[CTRL_BOR_EN] && pin_ok
                                   && !por_act && !pulse_req) |=> core_run_ff)
        else $error("brown-out reset while disabled");
    por_once_a: assert property (por_done_ff |-> tap_rst_n_ff)
        else $error("power-on request after initial power-up");
endmodule

// [inc/rcs_pkg.sv]
// constants, register map and state encoding of the reset control sequencer
package rcs_pkg;
    // apb register byte addresses
    localparam int APB_AW = 8;
    localparam logic [7:0] ADDR_CAUSE = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_SRST = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    // reset_cause_flags bit positions
    localparam int CAUSE_EXT = 0;
    localparam int CAUSE_POR = 1;
    localparam int CAUSE_BOR = 2;
    localparam int CAUSE_WDT = 3;
    localparam int CAUSE_SW = 4;
    localparam int CAUSE_W = 5;
    // control bits
    localparam int CTRL_BOR_EN = 0;
    localparam int CTRL_WDT_EN = 1;
    localparam int CTRL_W = 2;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // interrupt status bits
    localparam int IRQ_BOR = 0;
    localparam int IRQ_BOOT = 1;
    localparam int IRQ_W = 2;
    // timing: least width of the internal reset after every source is gone
    localparam int CLK_PERIOD_NS = 100;
    localparam int RST_MIN_NS = 1000;
    localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // boot vector addresses
    localparam logic [31:0] VEC_SP = 32'h0000_0000;
    localparam logic [31:0] VEC_PC = 32'h0000_0004;
    // sequencer states
    typedef enum logic [2:0] {
        ST_HOLD = 3'b000,
        ST_STRETCH = 3'b001,
        ST_FETCH_SP = 3'b010,
        ST_FETCH_PC = 3'b011,
        ST_FETCH_INSN = 3'b100,
        ST_RUN = 3'b101
    } rcs_state_t;
endpackage

// [rtl/rcs_sync.sv]
// three-stage synchroniser with agreement filter for asynchronous level inputs
`timescale 1ns/1ps
module rcs_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic [WIDTH-1:0] async_in, // levels from outside the clock domain
    output logic [WIDTH-1:0] sync_out // filtered synchronous levels
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] out_ff;
    logic [WIDTH-1:0] nxt_out;

    // elaboration refuses a width that the logic cannot serve
    if (WIDTH < 1) begin : g_bad_width
        $error("rcs_sync: WIDTH must be at least 1");
    end

    // a change counts only once stages two and three agree; s1 feeds s2 alone
    assign nxt_out = (s2_ff & s3_ff) | (out_ff & (s2_ff | s3_ff));
    assign sync_out = out_ff;

    // reset values are constants, so the held-in-reset sense is chosen per bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff <= RESET_VAL;
            s2_ff <= RESET_VAL;
            s3_ff <= RESET_VAL;
            out_ff <= RESET_VAL;
        end else begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            out_ff <= nxt_out;
        end
    end
endmodule

// [bench/rcs_supply_model.sv]
// behavioural model of the reset pin circuit, supply monitors and boot memory
`timescale 1ns/1ps
module rcs_supply_model
    import rcs_pkg::*;
#(
    parameter logic [31:0] SP_VAL = 32'h2000_0ff0,
    parameter logic [31:0] PC_VAL = 32'h0000_0101
) (
    input wire logic pclk, // system clock
    input wire logic pin_low_cmd, // bench pulls the pin low
    input wire logic por_cmd, // bench holds the supply below threshold
    input wire logic bor_cmd, // bench dips the supply
    input wire logic boot_req, // fetch request from the sequencer
    input wire logic [31:0] boot_addr, // fetch address
    output logic rst_pin_n, // reset pin, pulled up when released
    output logic por_n, // power-on detector, low while active
    output logic bor_detect, // brown-out detector, high while active
    output logic boot_ack, // fetch data valid
    output logic [31:0] boot_rdata // fetch data
);
    logic [31:0] last_ff;
    logic [31:0] word;
    // pin driven low then let go; the pull-up brings it back high
    assign rst_pin_n = ~pin_low_cmd;
    assign por_n = ~por_cmd;
    assign bor_detect = bor_cmd;
    // image: stack pointer, program counter, then code derived from the address
    assign word = (boot_addr == VEC_SP) ? SP_VAL :
                  (boot_addr == VEC_PC) ? PC_VAL : (boot_addr ^ 32'hc0de_0000);
    // idle bus shows the inverse of the last word so stale data cannot pass
    assign boot_rdata = boot_ack ? word : ~last_ff;
    // ack every other cycle, slower than the sequencer allows
    always_ff @(posedge pclk) begin
        boot_ack <= boot_req & ~boot_ack;
        if (boot_ack) begin
            last_ff <= word;
        end
    end
endmodule

// [bench/tb_top.sv]
// self-checking bench: power-up, pin, brown-out, software, watchdog, peripheral resets
`timescale 1ns/1ps
module tb_top
    import rcs_pkg::*;
;
    localparam int RC = 2;
    localparam logic [31:0] SP_VAL = 32'h2000_0ff0;
    localparam logic [31:0] PC_VAL = 32'h0000_0101;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rst_pin_n, por_n, bor_detect;
    logic sysreq, wdt, boot_ack, sys_rst_n, tap_rst_n, boot_req, core_run, irq;
    logic pin_low_cmd, por_cmd, bor_cmd, er;
    logic [7:0] paddr, periph_rst_n;
    logic [31:0] pwdata, prdata, boot_rdata, boot_addr, init_sp, init_pc, first_insn, rd;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc = 0;

    rcs_top #(.NPERIPH(8), .RST_CYC(RC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rst_pin_n(rst_pin_n), .por_n(por_n),
        .bor_detect(bor_detect), .system_reset_request(sysreq), .wdt_second_timeout(wdt),
        .boot_ack(boot_ack), .boot_rdata(boot_rdata), .sys_rst_n(sys_rst_n),
        .tap_rst_n(tap_rst_n), .periph_rst_n(periph_rst_n), .boot_req(boot_req),
        .boot_addr(boot_addr), .init_sp(init_sp), .init_pc(init_pc),
        .first_insn(first_insn), .core_run(core_run), .irq(irq));
    rcs_supply_model #(.SP_VAL(SP_VAL), .PC_VAL(PC_VAL)) model (.pclk(pclk),
        .pin_low_cmd(pin_low_cmd), .por_cmd(por_cmd), .bor_cmd(bor_cmd),
        .boot_req(boot_req), .boot_addr(boot_addr), .rst_pin_n(rst_pin_n), .por_n(por_n),
        .bor_detect(bor_detect), .boot_ack(boot_ack), .boot_rdata(boot_rdata));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    // one apb transfer; the slave's wait states are not assumed
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = pslverr;
        if (pready !== 1'b1) n_mismatch++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_run();
        int k;
        k = 0;
        while (core_run !== 1'b1 && k < 300) begin
            @(posedge pclk);
            k++;
        end
        #1;
        check(32'(core_run), 32'h1, "core restart");
        check(32'(boot_req), 32'h0, "fetch request dropped");
    endtask
    task automatic t_power_up();
        cycles(6);
        check(32'(tap_rst_n), 32'h0, "tap reset at power-on");
        @(posedge pclk);
        por_cmd <= 1'b0;
        cycles(20);
        check(32'(sys_rst_n), 32'h0, "held by later pin");
        @(posedge pclk);
        pin_low_cmd <= 1'b0;
        wait_run();
        check(init_sp, SP_VAL, "stack pointer");
        check(init_pc, PC_VAL, "program counter");
        check(first_insn, PC_VAL ^ 32'hc0de_0000, "first instruction");
        apb(1'b0, ADDR_CAUSE, 32'h0);
        check(rd, 32'h2, "power-on cause only");
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        check(rd, 32'h2, "boot finished event");
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rd, 32'h3b, "status after boot");
    endtask
    task automatic t_ext_pin();
        @(posedge pclk);
        pin_low_cmd <= 1'b1;
        cycles(10);
        check(32'(sys_rst_n), 32'h0, "pin resets core");
        check(32'(tap_rst_n), 32'h1, "pin spares tap");
        @(posedge pclk);
        pin_low_cmd <= 1'b0;
        cycles(3);
        check(32'(sys_rst_n), 32'h0, "release synchronised");
        wait_run();
        apb(1'b0, ADDR_CAUSE, 32'h0);
        check(rd, 32'h3, "pin flag, power-on kept");
    endtask
    // brown-out refused while disabled, still raises the interrupt; then enabled
    task automatic t_bor();
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd, 32'h0, "control reset value");
        apb(1'b1, ADDR_IRQ_STAT, 32'h3);
        apb(1'b1, ADDR_IRQ_MASK, 32'h1);
        cycles(2);
        check(32'(irq), 32'h0, "irq idle");
        @(posedge pclk);
        bor_cmd <= 1'b1;
        cycles(10);
        check(32'(sys_rst_n), 32'h1, "brown-out disabled");
        check(32'(irq), 32'h1, "brown-out irq");
        @(posedge pclk);
        bor_cmd <= 1'b0;
        cycles(6);
        apb(1'b1, ADDR_IRQ_STAT, 32'h1);
        apb(1'b1, ADDR_CAUSE, 32'h1f);
        cycles(3);
        check(32'(irq), 32'h0, "irq cleared");
        apb(1'b1, ADDR_CTRL, 32'h1);
        @(posedge pclk);
        bor_cmd <= 1'b1;
        cycles(12);
        check(32'(sys_rst_n), 32'h0, "held during brown-out");
        @(posedge pclk);
        bor_cmd <= 1'b0;
        wait_run();
        apb(1'b0, ADDR_CAUSE, 32'h0);
        check(rd, 32'h4, "brown-out cause");
        apb(1'b1, ADDR_CTRL, 32'h0);
    endtask
    task automatic t_sw_wdt();
        apb(1'b1, ADDR_CAUSE, 32'h1f);
        @(posedge pclk);
        wdt <= 1'b1;
        @(posedge pclk);
        wdt <= 1'b0;
        cycles(4);
        check(32'(core_run), 32'h1, "watchdog disabled");
        apb(1'b1, ADDR_CTRL, 32'h2);
        @(posedge pclk);
        sysreq <= 1'b1;
        wdt <= 1'b1;
        @(posedge pclk);
        sysreq <= 1'b0;
        wdt <= 1'b0;
        #1;
        check(32'(sys_rst_n), 32'h0, "reset next edge");
        wait_run();
        apb(1'b0, ADDR_CAUSE, 32'h0);
        check(rd, 32'h18, "both flags kept");
        apb(1'b1, ADDR_CTRL, 32'h0);
    endtask
    task automatic t_periph();
        apb(1'b1, ADDR_SRST, 32'h4);
        #1;
        check(32'(periph_rst_n), 32'hff, "set alone no reset");
        apb(1'b1, ADDR_SRST, 32'h0);
        #1;
        check(32'(periph_rst_n), 32'hfb, "reset on clear");
        cycles(1);
        check(32'(periph_rst_n), 32'hff, "one cycle pulse");
        apb(1'b0, 8'h20, 32'h0);
        check(32'(er), 32'h1, "unmapped error");
        check(rd, 32'h0, "unmapped data");
    endtask
    task automatic t_por_again();
        @(posedge pclk);
        por_cmd <= 1'b1;
        cycles(10);
        check(32'(sys_rst_n), 32'h1, "power-on ignored later");
        check(32'(tap_rst_n), 32'h1, "tap untouched later");
        @(posedge pclk);
        por_cmd <= 1'b0;
        cycles(5);
    endtask

    // free-running clock, 100 ns period
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // hang guard, well above the length of the sequence
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sysreq = 1'b0;
        wdt = 1'b0;
        pin_low_cmd = 1'b1;
        por_cmd = 1'b1;
        bor_cmd = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_power_up();
        t_ext_pin();
        t_bor();
        t_sw_wdt();
        t_periph();
        t_por_again();
        tally_and_finish();
    end
endmodule
